// [shared/itid_pkg.sv]
// How it works
// - Input pair: high nibble from port 4, main nibble from port 5.
// - Output: main nibble to port named by port select nibble.
// - Memory output: RAM nibble at pointer pair to selected port.
// - Direct output: main nibble to port in second-byte immediate.
// - Output pair: high to port 4, main to port 5, two cycles.
// - Bit test after bank change reads readable control registers.
// - Set bit forces one chosen port bit high, others kept.
// - Clear bit forces one chosen port bit low, updates zero flag.
// - Port AND with immediate, written back, updates zero flag.
// - Port OR with immediate, written back, updates zero flag.
// - Timer 0 reload from RAM pair at pointer plus main, two cycles.
// - Timer 1 reload from high and main nibbles, two cycles.
// - Timer reads: counter to RAM pair plus main, or high plus main.
// - Four two-cycle codes start or stop one timer each.
// - Two two-cycle codes set and clear master interrupt enable.
// - Enable codes OR immediate into upper or lower enable nibble.
// - Disable codes clear immediate bits of a nibble, update zero flag.
// - Stack pointer loads from, and reads into, high and main.
// - Serial write loads shift register from high and main; own start code.
// - Serial read copies shift register into high and main, two cycles.
// - All-zeros no-op takes one cycle and changes nothing.
// - Bank change swaps memory and register bank for next instruction.
package itid_pkg;
    // Single-byte opcodes
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_OUT_MAIN = 8'h25;
    localparam logic [7:0] OPC_OUT_MEM = 8'h1A;
    localparam logic [7:0] OPC_BANK = 8'h1B;
    localparam logic [7:0] OPC_BIT_MASK = 8'hFC;
    localparam logic [7:0] OPC_SET_BIT = 8'h08;
    localparam logic [7:0] OPC_CLR_BIT = 8'h28;
    // Two-byte first bytes
    localparam logic [7:0] OPC_PAIR = 8'hCD;
    localparam logic [7:0] OPC_DIRECT = 8'hC7;
    localparam logic [7:0] OPC_PORT_AND = 8'hC2;
    localparam logic [7:0] OPC_PORT_OR = 8'hC3;
    localparam logic [7:0] OPC_IRQ = 8'hCC;
    localparam logic [7:0] OPC_EXT = 8'hCF;
    // Second bytes
    localparam logic [7:0] SUB_IN_PAIR = 8'hF4;
    localparam logic [7:0] SUB_OUT_PAIR = 8'hF5;
    localparam logic [3:0] SUB_DIRECT_HI = 4'hF;
    localparam logic [3:0] SUB_EN_LO = 4'h4;
    localparam logic [3:0] SUB_EN_HI = 4'h5;
    localparam logic [3:0] SUB_DIS_LO = 4'h8;
    localparam logic [3:0] SUB_DIS_HI = 4'h9;
    localparam logic [7:0] SUB_WR_T0 = 8'h10;
    localparam logic [7:0] SUB_WR_T1 = 8'h11;
    localparam logic [7:0] SUB_RD_T0 = 8'h12;
    localparam logic [7:0] SUB_RD_T1 = 8'h13;
    localparam logic [7:0] SUB_RUN_T0 = 8'h14;
    localparam logic [7:0] SUB_RUN_T1 = 8'h15;
    localparam logic [7:0] SUB_HALT_T0 = 8'h16;
    localparam logic [7:0] SUB_HALT_T1 = 8'h17;
    localparam logic [7:0] SUB_MIE_ON = 8'h18;
    localparam logic [7:0] SUB_MIE_OFF = 8'h19;
    localparam logic [7:0] SUB_WR_SP = 8'h1A;
    localparam logic [7:0] SUB_RD_SP = 8'h1B;
    localparam logic [7:0] SUB_HALT = 8'h1C;
    localparam logic [7:0] SUB_HOLD = 8'h1D;
    localparam logic [7:0] SUB_SIO_GO = 8'h1E;
    localparam logic [7:0] SUB_WR_SIO = 8'h1F;
    localparam logic [7:0] SUB_RD_SIO = 8'h20;
    localparam logic [7:0] SUB_SEL_BANK = 8'h24;
    // Fixed port numbers of the pair instructions
    localparam logic [3:0] PORT_HIGH = 4'h4;
    localparam logic [3:0] PORT_LOW = 4'h5;
    // Reset values and pointer step
    localparam logic [3:0] PORT_RESET = 4'hF;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [7:0] PTR_STEP = 8'h01;
    typedef enum logic [0:0] {ST_IDLE, ST_SECOND} itid_state_t;
endpackage : itid_pkg

// [rtl/itid_pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module itid_pin_sync #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    wire [W-1:0] agree = ~(s2_q ^ s3_q);

    // A bit moves once stages two and three agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level <= '0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level <= (s2_q & agree) | (level & ~agree);
        end
    end
endmodule : itid_pin_sync
`default_nettype wire

// [rtl/itid_decoder.sv]
`timescale 1ns/1ns
`default_nettype none
module itid_decoder #(
    parameter int PORTS = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic instr_valid,
    output logic instr_ready,
    input wire logic [7:0] instr_byte0,
    input wire logic [7:0] instr_byte1,
    output logic instr_done,
    input wire logic [3:0] main_nibble_reg,
    input wire logic [3:0] high_nibble_reg,
    input wire logic [7:0] memory_pointer_pair,
    input wire logic [3:0] port_select_nibble,
    input wire logic [3:0] mem_rdata,
    input wire logic [3:0] mem_rdata_next,
    output logic main_wr,
    output logic [3:0] main_wdata,
    output logic high_wr,
    output logic [3:0] high_wdata,
    output logic zero_flag_wr,
    output logic zero_flag,
    output logic mem_wr,
    output logic [7:0] mem_waddr,
    output logic [3:0] mem_wdata,
    input wire logic [PORTS*4-1:0] port_pins,
    output logic [PORTS*4-1:0] port_out,
    input wire logic [3:0] ctrl_rd_data,
    input wire logic ctrl_rd_ok,
    output logic [3:0] test_nibble,
    output logic test_valid,
    output logic mem_bank_swap,
    output logic reg_bank_swap,
    output logic [1:0] pc_top,
    input wire logic [11:0] timer0_count,
    input wire logic [7:0] timer1_count,
    output logic timer0_load,
    output logic [11:0] timer0_reload,
    output logic timer1_load,
    output logic [7:0] timer1_reload,
    output logic timer0_run,
    output logic timer1_run,
    output logic master_irq_enable,
    output logic [3:0] irq_enable_upper,
    output logic [3:0] irq_enable_lower,
    input wire logic [7:0] stack_pointer,
    output logic stack_pointer_wr,
    output logic [7:0] stack_pointer_wdata,
    input wire logic [7:0] serial_shift_register,
    output logic serial_load,
    output logic [7:0] serial_wdata,
    output logic serial_start,
    output logic halt_req,
    output logic hold_req
);
    if (PORTS < 6 || PORTS > 16) begin : g_bad_ports
        $error("PORTS must lie between 6 and 16");
    end

    // Reset release through two flops
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Port pins are asynchronous to mclk
    logic [PORTS*4-1:0] pins_s;
    itid_pin_sync #(.W(PORTS*4)) u_pin_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin(port_pins),
        .level(pins_s)
    );

    itid_pkg::itid_state_t state_q;
    logic bank_q;
    logic [3:0] port_q [PORTS];
    logic [7:0] rd_addr2_q;
    logic [3:0] rd_nib2_q;

    // Instruction decode
    wire [7:0] b0 = instr_byte0;
    wire [7:0] b1 = instr_byte1;
    wire acc = instr_valid && (state_q == itid_pkg::ST_IDLE);
    wire is_nop = b0 == itid_pkg::OPC_NOP;
    wire is_op = b0 == itid_pkg::OPC_OUT_MAIN;
    wire is_opm = b0 == itid_pkg::OPC_OUT_MEM;
    wire is_bank = b0 == itid_pkg::OPC_BANK;
    wire is_spb = (b0 & itid_pkg::OPC_BIT_MASK) == itid_pkg::OPC_SET_BIT;
    wire is_rpb = (b0 & itid_pkg::OPC_BIT_MASK) == itid_pkg::OPC_CLR_BIT;
    wire is_input_port_pair = (b0 == itid_pkg::OPC_PAIR) && (b1 == itid_pkg::SUB_IN_PAIR);
    wire is_out_port_pair = (b0 == itid_pkg::OPC_PAIR) && (b1 == itid_pkg::SUB_OUT_PAIR);
    wire is_out_direct_port = (b0 == itid_pkg::OPC_DIRECT) && (b1[7:4] == itid_pkg::SUB_DIRECT_HI);
    wire is_and = b0 == itid_pkg::OPC_PORT_AND;
    wire is_or = b0 == itid_pkg::OPC_PORT_OR;
    wire is_irq = b0 == itid_pkg::OPC_IRQ;
    wire is_eil = is_irq && (b1[7:4] == itid_pkg::SUB_EN_LO);
    wire is_eih = is_irq && (b1[7:4] == itid_pkg::SUB_EN_HI);
    wire is_dil = is_irq && (b1[7:4] == itid_pkg::SUB_DIS_LO);
    wire is_dih = is_irq && (b1[7:4] == itid_pkg::SUB_DIS_HI);
    wire is_ext = b0 == itid_pkg::OPC_EXT;
    wire is_wt0 = is_ext && (b1 == itid_pkg::SUB_WR_T0);
    wire is_wt1 = is_ext && (b1 == itid_pkg::SUB_WR_T1);
    wire is_rt0 = is_ext && (b1 == itid_pkg::SUB_RD_T0);
    wire is_rt1 = is_ext && (b1 == itid_pkg::SUB_RD_T1);
    wire is_go0 = is_ext && (b1 == itid_pkg::SUB_RUN_T0);
    wire is_go1 = is_ext && (b1 == itid_pkg::SUB_RUN_T1);
    wire is_st0 = is_ext && (b1 == itid_pkg::SUB_HALT_T0);
    wire is_st1 = is_ext && (b1 == itid_pkg::SUB_HALT_T1);
    wire is_mon = is_ext && (b1 == itid_pkg::SUB_MIE_ON);
    wire is_moff = is_ext && (b1 == itid_pkg::SUB_MIE_OFF);
    wire is_wsp = is_ext && (b1 == itid_pkg::SUB_WR_SP);
    wire is_rsp = is_ext && (b1 == itid_pkg::SUB_RD_SP);
    wire is_halt = is_ext && (b1 == itid_pkg::SUB_HALT);
    wire is_hold = is_ext && (b1 == itid_pkg::SUB_HOLD);
    wire is_sgo = is_ext && (b1 == itid_pkg::SUB_SIO_GO);
    wire is_wsio = is_ext && (b1 == itid_pkg::SUB_WR_SIO);
    wire is_read_serial_shift = is_ext && (b1 == itid_pkg::SUB_RD_SIO);
    wire is_sb = is_ext && ((b1 & itid_pkg::OPC_BIT_MASK) == itid_pkg::SUB_SEL_BANK);
    // One-byte forms finish in one cycle
    wire one_cycle = is_nop | is_op | is_opm | is_bank | is_spb | is_rpb;

    // Port selection and read-modify-write on the output latch
    wire [3:0] p_sel = (is_and | is_or | is_out_direct_port) ? b1[3:0] : port_select_nibble;
    wire p_exists = 32'(p_sel) < PORTS;
    wire [3:0] lat_sel = p_exists ? port_q[p_sel] : itid_pkg::NIB_ZERO;
    wire [3:0] bit_mask = 4'(4'h1 << b0[1:0]);
    wire [3:0] set_res = lat_sel | bit_mask;
    wire [3:0] clr_res = lat_sel & ~bit_mask;
    wire [3:0] and_res = lat_sel & b1[7:4];
    wire [3:0] or_res = lat_sel | b1[7:4];
    wire [3:0] rmw_res = is_spb ? set_res : is_rpb ? clr_res : is_and ? and_res : or_res;

    // Single port write
    wire pw_en = acc & (is_op | is_opm | is_out_direct_port | is_spb | is_rpb | is_and | is_or);
    wire [3:0] pw_data = (is_op | is_out_direct_port) ? main_nibble_reg
                       : is_opm ? mem_rdata : rmw_res;
    wire pair_wr = acc & is_out_port_pair;

    // Interrupt enable arithmetic
    wire [3:0] en_lo_d = is_eil ? (irq_enable_lower | b1[3:0])
                       : (irq_enable_lower & ~b1[3:0]);
    wire [3:0] en_hi_d = is_eih ? (irq_enable_upper | b1[3:0])
                       : (irq_enable_upper & ~b1[3:0]);

    // Write-back selection toward core registers
    wire main_wr_d = acc & (is_input_port_pair | is_rt0 | is_rt1 | is_rsp | is_read_serial_shift);
    wire high_wr_d = acc & (is_input_port_pair | is_rt1 | is_rsp | is_read_serial_shift);
    wire [7:0] pair_rd = is_rt1 ? timer1_count
                       : is_rsp ? stack_pointer
                       : is_read_serial_shift ? serial_shift_register
                       : {pins_s[itid_pkg::PORT_HIGH*4 +: 4], pins_s[itid_pkg::PORT_LOW*4 +: 4]};
    wire [3:0] main_d = is_rt0 ? timer0_count[3:0] : pair_rd[3:0];
    wire zf_wr_d = acc & (is_rpb | is_and | is_or | is_dil | is_dih);
    wire [3:0] zf_src = is_dil ? en_lo_d : is_dih ? en_hi_d : rmw_res;
    wire [7:0] hl_next = memory_pointer_pair + itid_pkg::PTR_STEP;

    // Bit-test source for the branch unit
    wire [3:0] pin_sel = p_exists ? pins_s[p_sel*4 +: 4] : itid_pkg::NIB_ZERO;

    // Sequencing: one or two machine cycles
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= itid_pkg::ST_IDLE;
        end else begin
            case (state_q)
                itid_pkg::ST_IDLE: begin
                    if (acc && !one_cycle) begin
                        state_q <= itid_pkg::ST_SECOND;
                    end
                end
                itid_pkg::ST_SECOND: begin
                    state_q <= itid_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= itid_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign instr_ready = state_q == itid_pkg::ST_IDLE;

    // Completion pulse and core write-backs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            instr_done <= 1'b0;
            main_wr <= 1'b0;
            main_wdata <= itid_pkg::NIB_ZERO;
            high_wr <= 1'b0;
            high_wdata <= itid_pkg::NIB_ZERO;
            zero_flag_wr <= 1'b0;
            zero_flag <= 1'b0;
        end else begin
            instr_done <= (acc && one_cycle) || (state_q == itid_pkg::ST_SECOND);
            main_wr <= main_wr_d;
            main_wdata <= main_d;
            high_wr <= high_wr_d;
            high_wdata <= pair_rd[7:4];
            zero_flag_wr <= zf_wr_d;
            zero_flag <= zf_wr_d ? (zf_src == itid_pkg::NIB_ZERO) : zero_flag;
        end
    end

    // Timer 0 read spills into two RAM nibbles, one per cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr <= 1'b0;
            mem_waddr <= 8'h00;
            mem_wdata <= itid_pkg::NIB_ZERO;
            rd_addr2_q <= 8'h00;
            rd_nib2_q <= itid_pkg::NIB_ZERO;
        end else if (acc && is_rt0) begin
            mem_wr <= 1'b1;
            mem_waddr <= memory_pointer_pair;
            mem_wdata <= timer0_count[11:8];
            rd_addr2_q <= hl_next;
            rd_nib2_q <= timer0_count[7:4];
        end else if (state_q == itid_pkg::ST_SECOND && mem_wr) begin
            mem_waddr <= rd_addr2_q;
            mem_wdata <= rd_nib2_q;
        end else begin
            mem_wr <= 1'b0;
        end
    end

    // Output port latches
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PORTS; i++) begin
                port_q[i] <= itid_pkg::PORT_RESET;
            end
        end else begin
            if (pw_en && p_exists) begin
                port_q[p_sel] <= pw_data;
            end
            if (pair_wr) begin
                port_q[itid_pkg::PORT_HIGH] <= high_nibble_reg;
                port_q[itid_pkg::PORT_LOW] <= main_nibble_reg;
            end
        end
    end

    for (genvar g = 0; g < PORTS; g++) begin : g_port_out
        assign port_out[g*4 +: 4] = port_q[g];
    end

    // Bank swap lasts until next instruction
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bank_q <= 1'b0;
            test_nibble <= itid_pkg::NIB_ZERO;
            test_valid <= 1'b0;
        end else begin
            if (acc) begin
                bank_q <= is_bank;
            end
            test_nibble <= bank_q ? ctrl_rd_data : pin_sel;
            test_valid <= !bank_q || ctrl_rd_ok;
        end
    end

    assign mem_bank_swap = bank_q;
    assign reg_bank_swap = bank_q;

    // Timer, interrupt, stack, serial and standby control
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timer0_load <= 1'b0;
            timer0_reload <= 12'h000;
            timer1_load <= 1'b0;
            timer1_reload <= 8'h00;
            timer0_run <= 1'b0;
            timer1_run <= 1'b0;
            master_irq_enable <= 1'b0;
            irq_enable_upper <= itid_pkg::NIB_ZERO;
            irq_enable_lower <= itid_pkg::NIB_ZERO;
            stack_pointer_wr <= 1'b0;
            stack_pointer_wdata <= 8'h00;
            serial_load <= 1'b0;
            serial_wdata <= 8'h00;
            serial_start <= 1'b0;
            halt_req <= 1'b0;
            hold_req <= 1'b0;
            pc_top <= 2'h0;
        end else begin
            timer0_load <= acc & is_wt0;
            timer1_load <= acc & is_wt1;
            stack_pointer_wr <= acc & is_wsp;
            serial_load <= acc & is_wsio;
            serial_start <= acc & is_sgo;
            halt_req <= acc & is_halt;
            hold_req <= acc & is_hold;
            if (acc && is_wt0) begin
                timer0_reload <= {mem_rdata, mem_rdata_next, main_nibble_reg};
            end
            if (acc && is_wt1) begin
                timer1_reload <= {high_nibble_reg, main_nibble_reg};
            end
            if (acc && (is_go0 || is_st0)) begin
                timer0_run <= is_go0;
            end
            if (acc && (is_go1 || is_st1)) begin
                timer1_run <= is_go1;
            end
            if (acc && (is_mon || is_moff)) begin
                master_irq_enable <= is_mon;
            end
            if (acc && (is_eil || is_dil)) begin
                irq_enable_lower <= en_lo_d;
            end
            if (acc && (is_eih || is_dih)) begin
                irq_enable_upper <= en_hi_d;
            end
            if (acc && is_wsp) begin
                stack_pointer_wdata <= {high_nibble_reg, main_nibble_reg};
            end
            if (acc && is_wsio) begin
                serial_wdata <= {high_nibble_reg, main_nibble_reg};
            end
            if (acc && is_sb) begin
                pc_top <= b1[1:0];
            end
        end
    end
endmodule : itid_decoder
`default_nettype wire

// [tb/itid_decoder_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module itid_asserts #(
    parameter int PORTS = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [7:0] instr_byte0,
    input wire logic [7:0] instr_byte1,
    input wire logic instr_done,
    input wire logic [3:0] main_nibble_reg,
    input wire logic [3:0] high_nibble_reg,
    input wire logic [3:0] port_select_nibble,
    input wire logic main_wr,
    input wire logic high_wr,
    input wire logic mem_wr,
    input wire logic zero_flag_wr,
    input wire logic [PORTS*4-1:0] port_out,
    input wire logic timer0_run,
    input wire logic master_irq_enable,
    input wire logic stack_pointer_wr,
    input wire logic [7:0] stack_pointer_wdata,
    input wire logic serial_load,
    input wire logic [7:0] serial_wdata,
    input wire logic halt_req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Instruction accepted at this edge
    wire take = instr_valid && instr_ready;
    wire ext = take && instr_byte0 == itid_pkg::OPC_EXT;
    wire pair = take && instr_byte0 == itid_pkg::OPC_PAIR;
    a_nop_no_effect: assert property (take && instr_byte0 == itid_pkg::OPC_NOP |=> instr_done
        && !main_wr && !high_wr && !mem_wr && !zero_flag_wr && $stable(port_out))
        else $error("nop had effect");
    a_out_main_port: assert property (take && instr_byte0 == itid_pkg::OPC_OUT_MAIN |=> instr_done
        && port_out[$past(port_select_nibble)*4 +: 4] == $past(main_nibble_reg))
        else $error("out port wrong");
    a_direct_port: assert property (take && instr_byte0 == itid_pkg::OPC_DIRECT
        |=> port_out[$past(instr_byte1[3:0])*4 +: 4] == $past(main_nibble_reg) ##1 instr_done)
        else $error("direct output port wrong");
    a_pair_out_ports: assert property (pair && instr_byte1 == itid_pkg::SUB_OUT_PAIR |=> !instr_ready
        && port_out[23:16] == {$past(main_nibble_reg), $past(high_nibble_reg)} ##1 instr_done)
        else $error("output pair ports wrong");
    a_pair_in_write: assert property (pair && instr_byte1 == itid_pkg::SUB_IN_PAIR
        |=> high_wr && main_wr ##1 instr_done)
        else $error("in pair wrong");
    a_timer0_start: assert property (ext && instr_byte1 == itid_pkg::SUB_RUN_T0
        |-> ##2 timer0_run && instr_done)
        else $error("timer 0 not run");
    a_master_irq_en: assert property (ext && (instr_byte1 == itid_pkg::SUB_MIE_ON
        || instr_byte1 == itid_pkg::SUB_MIE_OFF)
        |-> ##2 master_irq_enable == $past(instr_byte1 == itid_pkg::SUB_MIE_ON, 2))
        else $error("master enable wrong");
    a_sp_load_data: assert property (ext && instr_byte1 == itid_pkg::SUB_WR_SP |=> stack_pointer_wr
        && stack_pointer_wdata == $past({high_nibble_reg, main_nibble_reg}))
        else $error("sp load wrong");
    a_sio_load_data: assert property (ext && instr_byte1 == itid_pkg::SUB_WR_SIO |=> serial_load
        && serial_wdata == $past({high_nibble_reg, main_nibble_reg}))
        else $error("serial load wrong");
    a_halt_pulse: assert property (ext && instr_byte1 == itid_pkg::SUB_HALT
        |=> halt_req ##1 !halt_req && instr_done)
        else $error("halt not one pulse");
endmodule : itid_asserts
bind itid_decoder itid_asserts #(.PORTS(PORTS)) i_itid_asserts (.*);
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic instr_valid = 1'b0, ctrl_rd_ok = 1'b0;
    logic [7:0] instr_byte0 = 8'h00, instr_byte1 = 8'h00, memory_pointer_pair = 8'h00;
    logic [3:0] main_nibble_reg = 4'h0, high_nibble_reg = 4'h0, port_select_nibble = 4'h0;
    logic [3:0] mem_rdata = 4'h0, mem_rdata_next = 4'h0, ctrl_rd_data = 4'h0;
    logic [63:0] port_pins = 64'h0;
    logic [11:0] timer0_count = 12'h000;
    logic [7:0] timer1_count = 8'h00, stack_pointer = 8'h00, serial_shift_register = 8'h00;
    logic instr_ready, instr_done, main_wr, high_wr, zero_flag_wr, zero_flag, mem_wr, test_valid;
    logic mem_bank_swap, reg_bank_swap, timer0_load, timer1_load, timer0_run, timer1_run;
    logic master_irq_enable, stack_pointer_wr, serial_load, serial_start, halt_req, hold_req;
    logic [3:0] main_wdata, high_wdata, mem_wdata, test_nibble, irq_enable_upper, irq_enable_lower;
    logic [7:0] mem_waddr, timer1_reload, stack_pointer_wdata, serial_wdata, cap_t1, cap_sp, cap_sio;
    logic [63:0] port_out;
    logic [11:0] timer0_reload, cap_t0, exp;
    logic [1:0] pc_top;
    logic [3:0] cap_main, cap_high;
    logic [3:0] mem_img [256];
    int error_cnt = 0, checks = 0, cyc = 0, n_start = 0, n_halt = 0, n_hold = 0;

    itid_decoder #(.PORTS(16)) i_itid_decoder (.*);

    // 10 MHz machine clock
    always #50 mclk = ~mclk;

    // Catch one-cycle write pulses
    always @(posedge mclk) begin
        if (main_wr) cap_main <= main_wdata;
        if (high_wr) cap_high <= high_wdata;
        if (mem_wr) mem_img[mem_waddr] <= mem_wdata;
        if (timer0_load) cap_t0 <= timer0_reload;
        if (timer1_load) cap_t1 <= timer1_reload;
        if (stack_pointer_wr) cap_sp <= stack_pointer_wdata;
        if (serial_load) cap_sio <= serial_wdata;
        if (serial_start) n_start <= n_start + 1;
        if (halt_req) n_halt <= n_halt + 1;
        if (hold_req) n_hold <= n_hold + 1;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One instruction, cycles to done
    task automatic go(input logic [7:0] b0, input logic [7:0] b1);
        int k;
        k = 0;
        instr_byte0 = b0;
        instr_byte1 = b1;
        instr_valid = 1'b1;
        while (instr_ready !== 1'b1 && k < 20) begin
            @(negedge mclk);
            k++;
        end
        @(negedge mclk);
        instr_valid = 1'b0;
        cyc = 1;
        while (instr_done !== 1'b1 && cyc < 20) begin
            @(negedge mclk);
            cyc++;
        end
        if (k >= 20 || cyc >= 20) begin
            error_cnt++;
            $display("MISMATCH done expected 1 seen timeout");
            give_verdict();
        end
        @(negedge mclk);
    endtask : go

    initial begin
        repeat (16) @(negedge mclk);
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        main_nibble_reg = 4'hA;
        port_select_nibble = 4'h3;
        go(itid_pkg::OPC_OUT_MAIN, 8'h00);
        chk("port3", 12'hA, port_out[15:12]);
        mem_rdata = 4'h5;
        port_select_nibble = 4'h6;
        go(itid_pkg::OPC_OUT_MEM, 8'h00);
        chk("port6", 12'h5, port_out[27:24]);
        main_nibble_reg = 4'hC;
        go(itid_pkg::OPC_DIRECT, {itid_pkg::SUB_DIRECT_HI, 4'h9});
        chk("port9", 12'hC, port_out[39:36]);
        high_nibble_reg = 4'h1;
        main_nibble_reg = 4'h2;
        go(itid_pkg::OPC_PAIR, itid_pkg::SUB_OUT_PAIR);
        chk("pair_cycles", 12'h2, 12'(cyc));
        chk("port45", 12'h21, port_out[23:16]);
        port_pins[23:16] = 8'h87;
        repeat (8) @(negedge mclk);
        go(itid_pkg::OPC_PAIR, itid_pkg::SUB_IN_PAIR);
        chk("in_pair", 12'h78, {cap_high, cap_main});
        $display("test port output done");
        port_select_nibble = 4'h3;
        go(itid_pkg::OPC_SET_BIT + 8'h02, 8'h00);
        chk("set_bit", 12'hE, port_out[15:12]);
        exp = 12'hE;
        for (int i = 0; i < 4; i++) begin
            go(itid_pkg::OPC_CLR_BIT + 8'(i), 8'h00);
            exp[i] = 1'b0;
            chk("clr_bit", exp, port_out[15:12]);
            chk("clr_zf", exp == 12'h0, zero_flag);
        end
        go(itid_pkg::OPC_PORT_AND, 8'h69);
        chk("and1", 12'h04, {zero_flag, port_out[39:36]});
        go(itid_pkg::OPC_PORT_AND, 8'h39);
        chk("and2", 12'h10, {zero_flag, port_out[39:36]});
        go(itid_pkg::OPC_PORT_OR, 8'h59);
        chk("or", 12'h05, {zero_flag, port_out[39:36]});
        $display("test port bits done");
        mem_rdata = 4'h1;
        mem_rdata_next = 4'h2;
        main_nibble_reg = 4'h3;
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_WR_T0);
        chk("t0_reload", 12'h123, cap_t0);
        high_nibble_reg = 4'h4;
        main_nibble_reg = 4'h5;
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_WR_T1);
        chk("t1_reload", 12'h45, cap_t1);
        memory_pointer_pair = 8'h20;
        timer0_count = 12'hABC;
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_RD_T0);
        chk("t0_read", 12'hABC, {mem_img[8'h20], mem_img[8'h21], cap_main});
        timer1_count = 8'h9D;
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_RD_T1);
        chk("t1_read", 12'h9D, {cap_high, cap_main});
        for (int i = 0; i < 4; i++) begin
            go(itid_pkg::OPC_EXT, itid_pkg::SUB_RUN_T0 + 8'(i));
            chk("timer_runs", (8'h2D >> (2 * i)) & 8'h03, {timer1_run, timer0_run});
        end
        $display("test timers done");
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_MIE_ON);
        chk("mie_on", 12'h1, master_irq_enable);
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_MIE_OFF);
        chk("mie_off", 12'h0, master_irq_enable);
        go(itid_pkg::OPC_IRQ, {itid_pkg::SUB_EN_LO, 4'h5});
        go(itid_pkg::OPC_IRQ, {itid_pkg::SUB_EN_HI, 4'hA});
        chk("irq_en", 12'hA5, {irq_enable_upper, irq_enable_lower});
        go(itid_pkg::OPC_IRQ, {itid_pkg::SUB_DIS_LO, 4'h4});
        chk("dis_lo", 12'h0A1, {zero_flag, irq_enable_upper, irq_enable_lower});
        go(itid_pkg::OPC_IRQ, {itid_pkg::SUB_DIS_HI, 4'hA});
        chk("dis_hi", 12'h101, {zero_flag, irq_enable_upper, irq_enable_lower});
        $display("test interrupt enables done");
        high_nibble_reg = 4'h6;
        main_nibble_reg = 4'h7;
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_WR_SP);
        chk("sp_load", 12'h67, cap_sp);
        stack_pointer = 8'h3E;
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_RD_SP);
        chk("sp_read", 12'h3E, {cap_high, cap_main});
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_WR_SIO);
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_SIO_GO);
        chk("sio_load", 12'h167, {n_start[3:0], cap_sio});
        serial_shift_register = 8'hC4;
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_RD_SIO);
        chk("sio_read", 12'hC4, {cap_high, cap_main});
        $display("test stack and serial done");
        go(itid_pkg::OPC_NOP, 8'h00);
        chk("nop_cycles", 12'h1, 12'(cyc));
        chk("nop_port9", 12'h5, port_out[39:36]);
        ctrl_rd_data = 4'h9;
        ctrl_rd_ok = 1'b1;
        go(itid_pkg::OPC_BANK, 8'h00);
        chk("bank_swap", 12'h3, {mem_bank_swap, reg_bank_swap});
        chk("ctrl_test", 12'h9, test_nibble);
        go(itid_pkg::OPC_NOP, 8'h00);
        chk("bank_back", 12'h0, {mem_bank_swap, reg_bank_swap});
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_HALT);
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_HOLD);
        chk("standby", 12'h11, {n_halt[3:0], n_hold[3:0]});
        go(itid_pkg::OPC_EXT, itid_pkg::SUB_SEL_BANK + 8'h02);
        chk("pc_top", 12'h2, pc_top);
        $display("test bank and standby done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
